// ===== verification/periph_model.sv
`timescale 1ns/1ns
module periph_model
    import pin_function_select_pkg::*;
(
    // Pin drive from the block
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    // Board levels and peripheral pattern
    input  wire logic [NUM_PINS-1:0] ext_val,
    input  wire logic [31:0]         pwm_pat,
    // Toward the block
    output logic      [NUM_PINS-1:0] pin_in,
    output logic      [31:0]         func_out,
    output logic      [31:0]         func_oe
);
    // A pin reads its own driver when enabled, else the board level
    assign pin_in   = (pin_oe & pin_out) | (~pin_oe & ext_val);
    // Peripherals always enable; only the mux may gate them
    assign func_out = pwm_pat;
    assign func_oe  = 32'hffff_ffff;
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import pin_function_select_pkg::*;
;
    typedef struct packed {logic [4:0] sel; logic pol, out, oe;} row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, func_out, func_oe, func_in, r;
    logic [31:0] pwm_pat = 32'h2800_0000;
    logic [3:0]  pstrb = 4'hf;
    logic [NUM_PINS-1:0] port_out = 10'h001, port_oe = 10'h001;
    logic [NUM_PINS-1:0] ext_val = '0, pin_in, pin_out, pin_oe;
    logic pready, pslverr, e;
    int   mismatches = 0, comparisons = 0;
    row_t rows [10];
    pin_function_select pin_function_select_i (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_out(port_out),
        .port_oe(port_oe), .func_out(func_out), .func_oe(func_oe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .func_in(func_in));
    periph_model periph_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_val(ext_val), .pwm_pat(pwm_pat), .pin_in(pin_in),
        .func_out(func_out), .func_oe(func_oe));
    // Free-running bus clock
    always #20 pclk = ~pclk;
    //////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, x);
        comparisons++;
        if (s !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    // Byte address of a per-pin register: four times the word index
    function automatic logic [17:0] ra(input logic [15:0] b, input int i);
        ra = {b + PIN_OFS[i], 2'b00};
    endfunction
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [17:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            close_out();
        end else begin
            r = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{CODE_LOW,  1'b0, 1'b0, 1'b1},
                 '{CODE_LOW,  1'b1, 1'b1, 1'b1},
                 '{CODE_HIGH, 1'b0, 1'b1, 1'b1},
                 '{CODE_HIGH, 1'b1, 1'b0, 1'b1},
                 '{CODE_PWM_CHANNEL_TWO_OUT, 1'b1, 1'b1, 1'b1},
                 '{CODE_PWM_CHANNEL_THREE_OUT, 1'b0, 1'b0, 1'b1},
                 '{CODE_PWM_CHANNEL_FOUR_OUT, 1'b0, 1'b1, 1'b1},
                 '{CODE_PWM_CHANNEL_FIVE_OUT, 1'b0, 1'b0, 1'b1},
                 '{CODE_PORT, 1'b1, 1'b1, 1'b1},
                 '{CODE_IDX,  1'b0, 1'b0, 1'b0}};
        repeat (3) @(posedge pclk);
        // Pins come up forced low while held in reset
        check("pin_oe", 32'(pin_oe), 32'h0000_03ff);
        check("pin_out", 32'(pin_out), 32'h0000_0000);
        presetn <= 1;
        // Table of codes on pin p0_0, with read-back of the field
        foreach (rows[i]) begin
            apb(1'b1, ra(IO_CFG_BASE, 0), {31'h0, rows[i].pol});
            apb(1'b1, ra(FUNC_SEL_BASE, 0), {27'h0, rows[i].sel});
            apb(1'b0, ra(FUNC_SEL_BASE, 0), 32'h0);
            check("select", r & 32'h1f, {27'h0, rows[i].sel});
            repeat (2) @(posedge pclk);
            check("pin_oe", 32'(pin_oe[0]), 32'(rows[i].oe));
            if (rows[i].oe)
                check("pin_out", 32'(pin_out[0]), 32'(rows[i].out));
        end
        // Input code carries the board level both ways
        ext_val <= 10'h001;
        repeat (3) @(posedge pclk);
        check("index_in", 32'(func_in[CODE_IDX]), 32'h1);
        check("phase_in", 32'(func_in[CODE_PHA]), 32'h0);
        ext_val <= 10'h000;
        repeat (3) @(posedge pclk);
        check("index_in", 32'(func_in[CODE_IDX]), 32'h0);
        // Successive writes, with psel low a cycle between them, force every pin high, incl. sparse offset
        for (int i = 0; i < NUM_PINS; i++) begin
            apb(1'b1, ra(FUNC_SEL_BASE, i), 32'h1f);
        end
        repeat (2) @(posedge pclk);
        check("pin_out", 32'(pin_out), 32'h0000_03ff);
        // Unmapped word answers with an error and zero data
        apb(1'b0, 18'h0_0004, 32'h0);
        check("pslverr", 32'(e), 32'h1);
        check("prdata", r, 32'h0);
        // Unmapped write is refused and leaves every pin as it was
        apb(1'b1, 18'h0_0004, 32'h0);
        check("pslverr", 32'(e), 32'h1);
        check("pin_out", 32'(pin_out), 32'h0000_03ff);
        // Write without the low byte strobe is dropped
        pstrb <= 4'he;
        apb(1'b1, ra(FUNC_SEL_BASE, 0), 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, ra(FUNC_SEL_BASE, 0), 32'h0);
        check("select", r, 32'h0000_001f);
        // Polarity on the sparse pin, with read-back of its config word
        apb(1'b1, ra(IO_CFG_BASE, 9), 32'h0000_0001);
        apb(1'b0, ra(IO_CFG_BASE, 9), 32'h0);
        check("io_config", r, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check("pin_out", 32'(pin_out), 32'h0000_01ff);
        // Reset in mid-run drops every pin back to forced low
        presetn <= 0;
        @(posedge pclk);
        check("pin_out", 32'(pin_out), 32'h0000_0000);
        check("pin_oe", 32'(pin_oe), 32'h0000_03ff);
        presetn <= 1;
        apb(1'b0, ra(FUNC_SEL_BASE, 9), 32'h0);
        check("select", r, 32'h0);
        apb(1'b0, ra(IO_CFG_BASE, 9), 32'h0);
        check("io_config", r, 32'h0);
        close_out();
    end
endmodule

// ===== verilog/func_input_router.sv
`timescale 1ns/1ns
module func_input_router
    import pin_function_select_pkg::*;
(
    // Per-pin selection and pin level
    input  wire logic [NUM_PINS-1:0][4:0] sel,
    input  wire logic [NUM_PINS-1:0]      pin_in,
    // Level seen by each input function
    output logic      [31:0]              route
);

    // Two pins on one input function are ORed; software should avoid it
    always_comb begin
        route = 32'h0000_0000;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (is_input_code(sel[p])) begin
                route[sel[p]] = route[sel[p]] | pin_in[p];
            end
        end
    end

endmodule

// ===== verilog/pin_function_select.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Codes 11011-11110 drive PWM channels 2-5
// - Code 11111 forces pin high
// - Polarity setting inverts forced levels
// - Reset clears every select field to zero
// - Code 00000 forces pin low
module pin_function_select
    import pin_function_select_pkg::*;
(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic [17:0]         paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Port bits per pin
    input  wire logic [NUM_PINS-1:0] port_out,
    input  wire logic [NUM_PINS-1:0] port_oe,
    // Peripheral outputs indexed by function code
    input  wire logic [31:0]         func_out,
    input  wire logic [31:0]         func_oe,
    // Pins
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe,
    // Peripheral inputs indexed by function code
    output logic      [31:0]         func_in
);

    //////////////////////////////////////////////////////////////////////////
    // State

    // Every output is a field here, so each one leaves a flop
    typedef struct packed {
        logic [NUM_PINS-1:0][4:0] sel;
        logic [NUM_PINS-1:0]      pol;
        logic [NUM_PINS-1:0]      out;
        logic [NUM_PINS-1:0]      oe;
        logic [31:0]              fin;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
    } state_t;

    state_t                   q;
    state_t                   d;
    logic [NUM_PINS-1:0]      mux_out;
    logic [NUM_PINS-1:0]      mux_oe;
    logic [31:0]              route;
    logic [5:0]               dec;
    logic                     hit;
    logic                     is_io;
    logic [3:0]               pin_idx;

    //////////////////////////////////////////////////////////////////////////
    // Per-pin output select and input routing

    // One select cell per pin; the cells are pure logic and the
    // registers below add the single cycle of pin latency
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        pin_mux_cell u_cell (
            .sel      (q.sel[p]),
            .pol      (q.pol[p]),
            .port_out (port_out[p]),
            .port_oe  (port_oe[p]),
            .func_out (func_out),
            .func_oe  (func_oe),
            .drv_out  (mux_out[p]),
            .drv_oe   (mux_oe[p])
        );
    end

    func_input_router u_router (
        .sel    (q.sel),
        .pin_in (pin_in),
        .route  (route)
    );

    //////////////////////////////////////////////////////////////////////////
    // Next state

    // Address decode shared by read and write
    assign dec     = addr_decode(paddr);
    assign hit     = dec[5];
    assign is_io   = dec[4];
    assign pin_idx = dec[3:0];

    // The answer is prepared one cycle ahead so pready comes from a flop;
    // this costs one wait state per access
    always_comb begin
        d     = q;
        d.out = mux_out;
        d.oe  = mux_oe;
        d.fin = route;
        if (psel && penable && q.pready) begin
            d.pready  = 1'b0;
            d.pslverr = 1'b0;
            d.prdata  = 32'h0000_0000;
            // Write lands on the edge that completes the access
            if (pwrite && hit && pstrb[0]) begin
                if (is_io) begin
                    d.pol[pin_idx] = pwdata[POL_BIT];
                end else begin
                    d.sel[pin_idx] = pwdata[4:0];
                end
            end
        end else if (psel && penable) begin
            d.pready  = 1'b1;
            d.pslverr = !hit;
            d.prdata  = 32'h0000_0000;
            if (hit && !pwrite) begin
                if (is_io) begin
                    d.prdata[POL_BIT] = q.pol[pin_idx];
                end else begin
                    d.prdata[4:0] = q.sel[pin_idx];
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers

    // Pins come up actively driving low
    // The reset branch loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q     <= '0;
            q.oe  <= '1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;
    assign pin_out = q.out;
    assign pin_oe  = q.oe;
    assign func_in = q.fin;

    //////////////////////////////////////////////////////////////////////////
    // Checks on pin 0, which the bench walks through the forced, PWM, port and index codes

    a_pwm_route : assert property (@(posedge pclk)
        disable iff (!presetn)
        (q.sel[0] >= CODE_PWM_CHANNEL_TWO_OUT && q.sel[0] <= CODE_PWM_CHANNEL_FIVE_OUT)
        |=> (pin_out[0] == $past(func_out[q.sel[0]])
             && pin_oe[0] == $past(func_oe[q.sel[0]])))
        else $error("pwm channel not routed to pin");

    a_forced_high : assert property (@(posedge pclk)
        disable iff (!presetn)
        (q.sel[0] == CODE_HIGH && !q.pol[0])
        |=> (pin_out[0] && pin_oe[0]))
        else $error("forced high not driven");

    a_polarity_flip : assert property (@(posedge pclk)
        disable iff (!presetn)
        ((q.sel[0] == CODE_HIGH || q.sel[0] == CODE_LOW) && q.pol[0])
        |=> (pin_out[0] == ($past(q.sel[0]) == CODE_LOW)))
        else $error("polarity did not invert forced level");

    // Reset leaves pins low
    // Looked at on the first edge after release, before any write lands
    a_reset_clear : assert property (@(posedge pclk)
        $rose(presetn)
        |-> (q.sel == '0 && pin_oe == '1 && pin_out == '0))
        else $error("select fields not cleared by reset");

    a_forced_low : assert property (@(posedge pclk)
        disable iff (!presetn)
        (q.sel[0] == CODE_LOW && !q.pol[0])
        |=> (!pin_out[0] && pin_oe[0]))
        else $error("forced low not driven");

    a_input_off : assert property (@(posedge pclk)
        disable iff (!presetn)
        is_input_code(q.sel[0])
        |=> (!pin_oe[0]
             && (!$past(pin_in[0]) || func_in[$past(q.sel[0])])))
        else $error("input function drives pin or loses level");

    //////////////////////////////////////////////////////////////////////////
    // Checks on every pin; the sparse p1_5 slot is the one most easily lost

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_chk
        a_pin_pwm : assert property (@(posedge pclk)
            disable iff (!presetn)
            (q.sel[p] >= CODE_PWM_CHANNEL_TWO_OUT && q.sel[p] <= CODE_PWM_CHANNEL_FIVE_OUT)
            |=> pin_oe[p] == $past(func_oe[q.sel[p]]))
            else $error("pwm code lost its output enable");

        a_pin_high : assert property (@(posedge pclk)
            disable iff (!presetn)
            q.sel[p] == CODE_HIGH
            |=> (pin_oe[p] && pin_out[p] == !$past(q.pol[p])))
            else $error("forced high wrong on a pin");

        a_pin_low : assert property (@(posedge pclk)
            disable iff (!presetn)
            q.sel[p] == CODE_LOW
            |=> (pin_oe[p] && pin_out[p] == $past(q.pol[p])))
            else $error("forced low wrong on a pin");

        // Port code follows the port bit
        a_pin_port : assert property (@(posedge pclk)
            disable iff (!presetn)
            q.sel[p] == CODE_PORT
            |=> (pin_out[p] == $past(port_out[p])
                 && pin_oe[p] == $past(port_oe[p])))
            else $error("port code not followed on a pin");

        a_pin_input : assert property (@(posedge pclk)
            disable iff (!presetn)
            is_input_code(q.sel[p]) |=> !pin_oe[p])
            else $error("input code drives a pin");
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks on the register bus

    // One wait state: ready comes on the second access edge
    a_ready_wait : assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable)
        |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");

    // Ready is a single-cycle pulse while the master holds the request
    a_ready_pulse : assert property (@(posedge pclk)
        disable iff (!presetn)
        (pready && psel && penable) |=> !pready)
        else $error("bus ready held past one cycle");

    // An error answer never stands without ready
    a_err_ready : assert property (@(posedge pclk)
        disable iff (!presetn)
        pslverr |-> pready)
        else $error("bus error without ready");

    // Read data is zero outside the answering cycle
    a_data_idle : assert property (@(posedge pclk)
        disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data left standing");

    // A select write to p0_0 lands on the edge that completes it
    a_write_lands : assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0]
         && paddr == {FUNC_SEL_BASE + PIN_OFS[0], 2'b00})
        |=> q.sel[0] == $past(pwdata[4:0]))
        else $error("select write did not land");

    // A select read of p0_0 returns the stored code
    a_read_back : assert property (@(posedge pclk)
        disable iff (!presetn)
        (pready && psel && !pwrite
         && paddr == {FUNC_SEL_BASE + PIN_OFS[0], 2'b00})
        |-> prdata == {27'h000_0000, q.sel[0]})
        else $error("select read returned wrong code");

    // Refused writes leave every field as it was
    a_err_dropped : assert property (@(posedge pclk)
        disable iff (!presetn)
        (pready && pslverr)
        |=> (q.sel == $past(q.sel) && q.pol == $past(q.pol)))
        else $error("refused write changed a field");

    // Without the low byte strobe a write is dropped silently
    a_strobe_off : assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && penable && pready && pwrite && !pstrb[0])
        |=> (q.sel == $past(q.sel) && q.pol == $past(q.pol)))
        else $error("write without strobe changed a field");

    // Main scenarios the bench should reach
    c_pwm_used : cover property (@(posedge pclk) disable iff (!presetn)
        q.sel[0] == CODE_PWM_CHANNEL_TWO_OUT ##1 pin_out[0]);
    c_inverted : cover property (@(posedge pclk) disable iff (!presetn)
        q.sel[0] == CODE_LOW && q.pol[0]);
    c_bad_addr : cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);
    c_input_seen : cover property (@(posedge pclk) disable iff (!presetn)
        func_in[CODE_IDX]);
    c_sparse_high : cover property (@(posedge pclk) disable iff (!presetn)
        q.sel[NUM_PINS-1] == CODE_HIGH);

endmodule

// ===== verilog/pin_function_select_pkg.sv
package pin_function_select_pkg;

    // Pin count and field widths
    localparam int          NUM_PINS        = 10;
    localparam int          CODE_W          = 5;
    localparam int          NUM_CODES       = 32;
    localparam int          ADDR_W          = 18;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] FUNC_SEL_BASE   = 16'ha120;
    localparam logic [15:0] IO_CFG_BASE     = 16'ha100;
    localparam logic [15:0] PIN_OFS [NUM_PINS] = '{
        16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
        16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h000d
    };

    // Field layout and reset values
    localparam int          POL_BIT         = 0;
    localparam logic [4:0]  SEL_RESET       = 5'h00;
    localparam logic        POL_RESET       = 1'b0;

    // Function codes
    localparam logic [4:0]  CODE_LOW        = 5'h00;
    localparam logic [4:0]  CODE_PORT       = 5'h01;
    localparam logic [4:0]  CODE_SDI        = 5'h03;
    localparam logic [4:0]  CODE_RX1        = 5'h0b;
    localparam logic [4:0]  CODE_RX2        = 5'h0d;
    localparam logic [4:0]  CODE_XCLK       = 5'h0f;
    localparam logic [4:0]  CODE_T0         = 5'h10;
    localparam logic [4:0]  CODE_T1         = 5'h11;
    localparam logic [4:0]  CODE_T2         = 5'h12;
    localparam logic [4:0]  CODE_IDX        = 5'h13;
    localparam logic [4:0]  CODE_PHA        = 5'h14;
    localparam logic [4:0]  CODE_PHB        = 5'h15;
    localparam logic [4:0]  CODE_CAPTURE_INPUT       = 5'h16;
    localparam logic [4:0]  CODE_PWM_CHANNEL_TWO_OUT       = 5'h1b;
    localparam logic [4:0]  CODE_PWM_CHANNEL_THREE_OUT       = 5'h1c;
    localparam logic [4:0]  CODE_PWM_CHANNEL_FOUR_OUT       = 5'h1d;
    localparam logic [4:0]  CODE_PWM_CHANNEL_FIVE_OUT       = 5'h1e;
    localparam logic [4:0]  CODE_HIGH       = 5'h1f;

    // Codes that feed a peripheral input and never drive the pin
    function automatic logic is_input_code(input logic [4:0] code);
        is_input_code = (code == CODE_SDI)  || (code == CODE_RX1)  ||
                        (code == CODE_RX2)  || (code == CODE_XCLK) ||
                        (code == CODE_T0)   || (code == CODE_T1)   ||
                        (code == CODE_T2)   || (code == CODE_IDX)  ||
                        (code == CODE_PHA)  || (code == CODE_PHB)  ||
                        (code == CODE_CAPTURE_INPUT);
    endfunction

    // Decode a byte address into {hit, io_cfg, pin index}
    function automatic logic [5:0] addr_decode(input logic [17:0] a);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (a[1:0] == 2'b00 && a[17:2] == FUNC_SEL_BASE + PIN_OFS[i]) begin
                r = {1'b1, 1'b0, 4'(i)};
            end
            if (a[1:0] == 2'b00 && a[17:2] == IO_CFG_BASE + PIN_OFS[i]) begin
                r = {1'b1, 1'b1, 4'(i)};
            end
        end
        addr_decode = r;
    endfunction

endpackage

// ===== verilog/pin_mux_cell.sv
`timescale 1ns/1ns
module pin_mux_cell
    import pin_function_select_pkg::*;
(
    // Configuration of this pin
    input  wire logic [4:0]  sel,
    input  wire logic        pol,
    // Sources
    input  wire logic        port_out,
    input  wire logic        port_oe,
    input  wire logic [31:0] func_out,
    input  wire logic [31:0] func_oe,
    // Pin drive
    output logic             drv_out,
    output logic             drv_oe
);

    // Output select for one pin
    always_comb begin
        drv_out = 1'b0;
        drv_oe  = 1'b0;
        if (sel == CODE_LOW) begin
            drv_out = 1'b0 ^ pol;
            drv_oe  = 1'b1;
        end else if (sel == CODE_HIGH) begin
            drv_out = 1'b1 ^ pol;
            drv_oe  = 1'b1;
        end else if (sel == CODE_PORT) begin
            drv_out = port_out;
            drv_oe  = port_oe;
        end else if (is_input_code(sel)) begin
            drv_out = 1'b0;
            drv_oe  = 1'b0;
        end else begin
            drv_out = func_out[sel];
            drv_oe  = func_oe[sel];
        end
    end

endmodule
